// file: src/tm0_cfg.svh
// constants of the 8-bit timer control and compare block: offsets, bits, resets
// assumes inclusion by bare name from the design module and the testbench
`ifndef TM0_CFG_SVH
`define TM0_CFG_SVH

// apb byte offsets of the register words
`define TM0_ADDR_CTRL 8'h00
`define TM0_ADDR_COUNT 8'h04
`define TM0_ADDR_CMP 8'h08
`define TM0_ADDR_FLAGS 8'h0C
`define TM0_ADDR_CFG 8'h10

// control register field positions
`define TM0_BIT_FORCE 7
`define TM0_BIT_WGM_LO 6
`define TM0_BIT_COM_HI 5
`define TM0_BIT_COM_LO 4
`define TM0_BIT_WGM_HI 3
`define TM0_BIT_CS_HI 2

// flag and config bit positions
`define TM0_BIT_OVF 0
`define TM0_BIT_CMP 1
`define TM0_BIT_ASYNC 0

// counter limits and reset values
`define TM0_MAX 8'hFF
`define TM0_BOTTOM 8'h00
`define TM0_RST_BYTE 8'h00
`define TM0_PRESC_W 10

`endif

// file: src/tm0_pkg.sv
// types shared by the timer control and compare block
// assumes the constants header is on the include path
package tm0_pkg;

  // waveform modes, binary codes written out
  typedef enum logic [1:0] {
    TM0_NORMAL = 2'b00,
    TM0_PC_PWM = 2'b01,
    TM0_CLEAR_ON_MATCH = 2'b10,
    TM0_FAST_PWM = 2'b11
  } tm0_wgm_type;

  // counting direction, only phase-correct uses down
  typedef enum logic {
    TM0_UP = 1'b0,
    TM0_DOWN = 1'b1
  } tm0_dir_type;

  // apb request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } tm0_apb_req_type;

  // apb answer to the master
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } tm0_apb_rsp_type;

  // the whole state of the block
  typedef struct packed {
    tm0_wgm_type wgm;
    logic [1:0] com;
    logic [2:0] cs;
    logic [7:0] count;
    logic [7:0] cmp_act;
    logic [7:0] cmp_buf;
    tm0_dir_type dir;
    logic oc;
    logic ovf;
    logic cmf;
    logic blk;
    logic async_sel;
    logic [2:0] sync;
    logic osc_lvl;
    logic [9:0] presc;
    logic [31:0] rdata;
  } tm0_state_type;

endpackage

// file: src/tm0_timer.sv
// 8-bit timer control and compare block with apb register access
// assumes an apb master on pclk; the port direction bit lives outside
//
// The address map and the APB register port were chosen for this implementation.
`include "tm0_cfg.svh"

module tm0_timer
  import tm0_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // register bus
  input wire tm0_apb_req_type apb_req,
  output tm0_apb_rsp_type apb_rsp,
  // timer oscillator, asynchronous to pclk
  input wire logic timer_osc_in,
  // compare output toward the port
  output logic compare_output_pin,
  output logic compare_output_override,
  // event flags toward the interrupt unit
  output logic overflow_flag,
  output logic compare_match_flag
);

  tm0_state_type q; // registered state
  tm0_state_type n; // next state

  // true for the register words that exist
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == `TM0_ADDR_CTRL) || (a == `TM0_ADDR_COUNT) ||
              (a == `TM0_ADDR_CMP) || (a == `TM0_ADDR_FLAGS) ||
              (a == `TM0_ADDR_CFG);
  endfunction

  // prescaler tap for a clock select value; counter value before increment
  function automatic logic tap_hit(input logic [2:0] cs, input logic [9:0] p);
    case (cs)
      3'h1: tap_hit = 1'b1;           // undivided source
      3'h2: tap_hit = &p[2:0];        // divide by 8
      3'h3: tap_hit = &p[4:0];        // divide by 32
      3'h4: tap_hit = &p[5:0];        // divide by 64
      3'h5: tap_hit = &p[6:0];        // divide by 128
      3'h6: tap_hit = &p[7:0];        // divide by 256
      3'h7: tap_hit = &p[9:0];        // divide by 1024
      default: tap_hit = 1'b0;        // stopped
    endcase
  endfunction

  // true for the two pwm modes
  function automatic logic is_pwm(input tm0_wgm_type m);
    is_pwm = (m == TM0_PC_PWM) || (m == TM0_FAST_PWM);
  endfunction

  // output after a match action: up selects the clear-on-10 sense
  function automatic logic match_act(input logic [1:0] com, input logic up,
                                     input logic cur);
    case (com)
      2'b10: match_act = ~up;
      2'b11: match_act = up;
      default: match_act = cur;
    endcase
  endfunction

  // bus phase decode
  logic setup_ph; // first cycle of a transfer
  logic wr_en; // write takes effect this edge
  assign setup_ph = apb_req.psel & ~apb_req.penable;
  assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite &
                 addr_ok(apb_req.paddr);

  // zero-wait slave: answer in the first access cycle
  always_comb begin
    apb_rsp.pready = apb_req.psel & apb_req.penable;
    apb_rsp.pslverr = apb_req.psel & apb_req.penable & ~addr_ok(apb_req.paddr);
    apb_rsp.prdata = q.rdata;
  end

  // pin and flag outputs straight from state flops
  assign compare_output_pin = q.oc;
  assign compare_output_override = |q.com;
  assign overflow_flag = q.ovf;
  assign compare_match_flag = q.cmf;

  // next-state logic: timer step, then software writes on top
  always_comb begin
    logic src_tick; // one source clock event
    logic tmr_en; // timer clock enable
    logic at_top; // counter at top this tick
    logic match; // live compare match
    logic up_eff; // direction a match acts in
    logic set_ovf; // overflow event
    logic set_cmf; // compare event
    logic [7:0] top_val; // top for the mode
    logic [7:0] wd; // written byte
    logic [7:0] ctrl_rd; // control as read back
    logic [7:0] cur_ocr; // compare value in use
    n = q;
    src_tick = 1'b1;
    tmr_en = 1'b0;
    at_top = 1'b0;
    match = 1'b0;
    up_eff = 1'b1;
    set_ovf = 1'b0;
    set_cmf = 1'b0;
    top_val = `TM0_MAX;
    wd = apb_req.pwdata[7:0];
    ctrl_rd = `TM0_RST_BYTE;
    cur_ocr = q.cmp_act;

    // oscillator: three flops, a level counts once stages two and three agree
    n.sync = {q.sync[1:0], timer_osc_in};
    if (q.sync[1] == q.sync[2]) begin
      n.osc_lvl = q.sync[2];
    end
    // async mode counts rising oscillator edges instead of pclk cycles
    if (q.async_sel) begin
      src_tick = (q.sync[1] == q.sync[2]) & q.sync[2] & ~q.osc_lvl;
    end

    // prescaler runs on source events; the tap gives the enable
    if (src_tick) begin
      n.presc = q.presc + 10'h001;
    end
    tmr_en = src_tick & tap_hit(q.cs, q.presc);

    // top of the sequence
    if (q.wgm == TM0_CLEAR_ON_MATCH) begin
      top_val = q.cmp_act;
    end
    at_top = (q.count == top_val);

    // compare every cycle; a counter write blocks the next tick's match
    match = (q.count == q.cmp_act) & ~q.blk;

    if (tmr_en) begin
      n.blk = 1'b0;
      set_cmf = match;
      case (q.wgm)
        TM0_NORMAL: begin
          n.count = q.count + 8'h01;
          set_ovf = (q.count == `TM0_MAX);
          if (match && q.com != 2'b00) begin
            n.oc = (q.com == 2'b01) ? ~q.oc : match_act(q.com, 1'b1, q.oc);
          end
        end
        TM0_CLEAR_ON_MATCH: begin
          // return to zero on the tick after the match value is reached
          n.count = at_top ? `TM0_BOTTOM : q.count + 8'h01;
          set_ovf = (q.count == `TM0_MAX);
          if (match && q.com != 2'b00) begin
            n.oc = (q.com == 2'b01) ? ~q.oc : match_act(q.com, 1'b1, q.oc);
          end
        end
        TM0_FAST_PWM: begin
          n.count = q.count + 8'h01;
          set_ovf = at_top;
          if (at_top) begin
            n.cmp_act = q.cmp_buf;
          end
          // compare at top with the high mode bit set: only the top action
          if (match && !(q.com[1] && q.cmp_act == `TM0_MAX)) begin
            n.oc = match_act(q.com, 1'b1, q.oc);
          end
          // the top action is the opposite of the match action
          if (at_top) begin
            n.oc = match_act(q.com, 1'b0, n.oc);
          end
        end
        TM0_PC_PWM: begin
          // up to max, turn at max without a hold tick, down to bottom
          if (q.dir == TM0_UP) begin
            if (at_top) begin
              n.count = `TM0_MAX - 8'h01;
              n.dir = TM0_DOWN;
              n.cmp_act = q.cmp_buf;
            end else begin
              n.count = q.count + 8'h01;
            end
          end else begin
            if (q.count == `TM0_BOTTOM) begin
              n.count = q.count + 8'h01;
              n.dir = TM0_UP;
              set_ovf = 1'b1;
            end else begin
              n.count = q.count - 8'h01;
            end
          end
          // a match at bottom belongs to the rising slope
          up_eff = (q.dir == TM0_UP) | (q.count == `TM0_BOTTOM);
          if (match && !(q.com[1] && q.cmp_act == `TM0_MAX)) begin
            n.oc = match_act(q.com, up_eff, q.oc);
          end
          if (at_top && q.com[1] && q.cmp_act == `TM0_MAX) begin
            n.oc = match_act(q.com, 1'b0, q.oc);
          end
        end
        default: begin
          n.count = q.count;
        end
      endcase
    end

    // software writes land at the access edge and win over the timer step
    if (wr_en) begin
      case (apb_req.paddr)
        `TM0_ADDR_CTRL: begin
          n.wgm = tm0_wgm_type'({wd[`TM0_BIT_WGM_HI], wd[`TM0_BIT_WGM_LO]});
          n.com = wd[`TM0_BIT_COM_HI:`TM0_BIT_COM_LO];
          n.cs = wd[`TM0_BIT_CS_HI:0];
          // strobe: not stored, acts with the mode bits of this same write
          if (wd[`TM0_BIT_FORCE] && !is_pwm(n.wgm) && n.com != 2'b00) begin
            n.oc = (n.com == 2'b01) ? ~q.oc : match_act(n.com, 1'b1, q.oc);
          end
        end
        `TM0_ADDR_COUNT: begin
          n.count = wd;
          n.blk = 1'b1;
        end
        `TM0_ADDR_CMP: begin
          n.cmp_buf = wd;
          if (!is_pwm(q.wgm)) begin
            n.cmp_act = wd;
          end
        end
        `TM0_ADDR_CFG: begin
          n.async_sel = wd[`TM0_BIT_ASYNC];
        end
        default: begin
          n.count = n.count;
        end
      endcase
    end

    // sticky flags: write one clears, a same-cycle event wins
    if (wr_en && apb_req.paddr == `TM0_ADDR_FLAGS) begin
      n.ovf = q.ovf & ~wd[`TM0_BIT_OVF];
      n.cmf = q.cmf & ~wd[`TM0_BIT_CMP];
    end
    n.ovf = n.ovf | set_ovf;
    n.cmf = n.cmf | set_cmf;

    // read data is captured in the setup cycle, so count is one cycle old
    ctrl_rd = {1'b0, q.wgm[0], q.com, q.wgm[1], q.cs};
    if (q.wgm == TM0_NORMAL) begin
      cur_ocr = q.cmp_buf;
    end
    if (setup_ph) begin
      case (apb_req.paddr)
        `TM0_ADDR_CTRL: n.rdata = {24'h000000, ctrl_rd};
        `TM0_ADDR_COUNT: n.rdata = {24'h000000, q.count};
        `TM0_ADDR_CMP: n.rdata = {24'h000000, q.cmp_buf};
        `TM0_ADDR_FLAGS: n.rdata = {30'h00000000, q.cmf, q.ovf};
        `TM0_ADDR_CFG: n.rdata = {31'h00000000, q.async_sel};
        default: n.rdata = 32'h00000000;
      endcase
    end
  end

  // one register for the whole state; reset clears everything
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

endmodule // tm0_timer

// file: verif/testbench.sv
// self-checking bench of the timer block over apb
// assumes tm0_timer, tm0_chk and tm0_port_pin compiled before it
`include "tm0_cfg.svh"
module testbench
  import tm0_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, osc, ddr, pad, pin, ovr, ovf, cmf, err;
  tm0_apb_req_type req;
  tm0_apb_rsp_type rsp;
  logic [31:0] r; // last read data
  int failures = 0, check_count = 0, seed, n, cyc = 0;
  int taps[8] = '{0, 1, 8, 32, 64, 128, 256, 1024}; // divide per clock select
  tm0_timer tm0_timer_inst (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .timer_osc_in(osc), .compare_output_pin(pin), .compare_output_override(ovr),
    .overflow_flag(ovf), .compare_match_flag(cmf));
  tm0_port_pin tm0_port_pin_inst (.pin_out(pin), .override(ovr), .ddr(ddr), .port_val(1'b0),
    .pad(pad));
  // 250 MHz bus clock and a slow unrelated oscillator
  initial begin
    pclk = 0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    osc = 0;
    forever #37 osc = ~osc;
  end
  // hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      failures++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer; an idle cycle follows so psel is never set twice at one edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    @(posedge pclk);
    // pready ends this wait; without pready only the hang guard ends it
    while (rsp.pready !== 1'b1) begin
      @(posedge pclk);
    end
    r = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    @(posedge pclk);
  endtask
  // cycles until overflow, seen at falling edges where values are settled
  task automatic wait_ovf(input int lim);
    n = 0;
    while (ovf !== 1'b1 && n < lim) begin
      @(negedge pclk);
      n++;
    end
    @(posedge pclk);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    logic ep;
    logic [31:0] v;
    seed = 30;
    req = '0;
    presetn = 0;
    ddr = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    for (int a = 0; a < 12; a += 4) begin
      apb(0, a[7:0], 0);
      chk(r, 0);
    end
    repeat (4) for (int a = 4; a < 12; a += 4) begin
      v = $random(seed);
      apb(1, a[7:0], v);
      apb(0, a[7:0], 0);
      chk(r, {24'h0, v[7:0]});
    end
    apb(0, 8'h14, 0);
    chk({r[30:0], err}, 1);
    $display("register test done");
    ep = pin;
    for (int c = 3; c > 0; c--) begin
      apb(1, `TM0_ADDR_CTRL, 32'h80 | (c << 4));
      ep = (c == 3) ? 1'b1 : (c == 2) ? 1'b0 : !ep;
      chk({cmf, pin}, {1'b0, ep});
    end
    // force in a pwm mode on purpose: it must do nothing
    apb(1, `TM0_ADDR_CTRL, 32'hF0);
    chk(pin, ep);
    apb(1, `TM0_ADDR_CTRL, 0);
    apb(1, `TM0_ADDR_COUNT, 0);
    apb(1, `TM0_ADDR_CMP, 32'h80);
    apb(1, `TM0_ADDR_CTRL, 32'h69);
    n = 0;
    repeat (512) begin
      @(negedge pclk);
      n += pin;
    end
    chk(n, 258);
    ddr <= 1;
    @(negedge pclk);
    chk({ovr, pad}, {1'b1, pin});
    @(posedge pclk);
    $display("force and pwm test done");
    apb(1, `TM0_ADDR_CTRL, 0);
    apb(1, `TM0_ADDR_COUNT, 32'hF0);
    apb(1, `TM0_ADDR_FLAGS, 3);
    apb(1, `TM0_ADDR_CTRL, 1);
    wait_ovf(100);
    chk(n, 16);
    for (int c = 2; c < 8; c++) begin
      apb(1, `TM0_ADDR_CTRL, 0);
      apb(1, `TM0_ADDR_COUNT, 32'hFE);
      apb(1, `TM0_ADDR_FLAGS, 3);
      apb(1, `TM0_ADDR_CTRL, c);
      wait_ovf(2100);
      chk(n > taps[c] && n <= 2 * taps[c], 1);
    end
    $display("prescaler test done");
    apb(1, `TM0_ADDR_CTRL, 0);
    apb(1, `TM0_ADDR_COUNT, 0);
    apb(1, `TM0_ADDR_CMP, 5);
    apb(1, `TM0_ADDR_FLAGS, 3);
    apb(1, `TM0_ADDR_CTRL, 32'h19);
    repeat (6) begin
      apb(0, `TM0_ADDR_COUNT, 0);
      chk(r <= 5, 1);
    end
    chk(cmf, 1);
    apb(1, `TM0_ADDR_CTRL, 0);
    apb(1, `TM0_ADDR_CFG, 1);
    apb(1, `TM0_ADDR_COUNT, 0);
    apb(1, `TM0_ADDR_CTRL, 1);
    repeat (400) @(posedge pclk);
    apb(1, `TM0_ADDR_CTRL, 0);
    apb(0, `TM0_ADDR_COUNT, 0);
    chk(r >= 19 && r <= 24, 1);
    presetn <= 0;
    @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, `TM0_ADDR_CFG, 0);
    chk(r, 0);
    $display("timing test done");
    end_of_test();
  end
endmodule // testbench
bind tm0_timer tm0_chk tm0_chk_inst (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .compare_output_pin(compare_output_pin),
  .compare_output_override(compare_output_override), .overflow_flag(overflow_flag),
  .compare_match_flag(compare_match_flag));

// file: verif/tm0_chk.sv
// checker of the timer block: bus answers, forced compares, reset state
// assumes a bind onto tm0_timer, rising pclk, presetn low active
module tm0_chk
  import tm0_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // register bus
  input wire tm0_apb_req_type apb_req,
  input wire tm0_apb_rsp_type apb_rsp,
  // timer outputs
  input wire logic compare_output_pin,
  input wire logic compare_output_override,
  input wire logic overflow_flag,
  input wire logic compare_match_flag
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc; // access cycle
  logic wc; // control write
  logic wf; // force strobe on a stopped counter
  logic [1:0] com_w; // written output mode
  logic [2:0] cs_q; // last written clock select
  assign acc = apb_req.psel && apb_req.penable;
  assign wc = acc && apb_req.pwrite && apb_req.paddr == 8'h00;
  assign com_w = apb_req.pwdata[5:4];
  assign wf = wc && apb_req.pwdata[7] && cs_q == 3'h0 && apb_req.pwdata[2:0] == 3'h0;
  // a running counter could match at the write edge, so forces are judged stopped only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cs_q <= 3'h0;
    else if (wc) cs_q <= apb_req.pwdata[2:0];
  end
  property p_rdy; apb_rsp.pready == acc; endproperty
  a_rdy: assert property (p_rdy) else $error("pready wrong");
  property p_err; apb_rsp.pslverr |-> acc; endproperty
  a_err: assert property (p_err) else $error("slverr outside access");
  property p_ovr; wc |=> compare_output_override == (|$past(com_w)); endproperty
  a_ovr: assert property (p_ovr) else $error("override wrong");
  property p_fset; wf && !apb_req.pwdata[6] && com_w == 2'h3 |=> compare_output_pin; endproperty
  a_fset: assert property (p_fset) else $error("force set failed");
  property p_fclr; wf && !apb_req.pwdata[6] && com_w == 2'h2 |=> !compare_output_pin; endproperty
  a_fclr: assert property (p_fclr) else $error("force clear failed");
  property p_ftog;
    wf && !apb_req.pwdata[6] && com_w == 2'h1 |=> compare_output_pin != $past(compare_output_pin);
  endproperty
  a_ftog: assert property (p_ftog) else $error("force toggle failed");
  property p_fpwm; wf && apb_req.pwdata[6] |=> $stable(compare_output_pin); endproperty
  a_fpwm: assert property (p_fpwm) else $error("force acted in pwm");
  property p_fflg; wf |=> $stable(compare_match_flag); endproperty
  a_fflg: assert property (p_fflg) else $error("force set a flag");
  property p_rd7; acc && !apb_req.pwrite && apb_req.paddr == 8'h00 |-> !apb_rsp.prdata[7]; endproperty
  a_rd7: assert property (p_rd7) else $error("force bit read one");
  property p_rst; $rose(presetn) |-> !overflow_flag && !compare_output_override; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  c_force: cover property (wf);
  c_ovf: cover property ($rose(overflow_flag));
  c_cmf: cover property ($rose(compare_match_flag));
endmodule // tm0_chk

// file: verif/tm0_port_pin.sv
// port pin model: the pad shows the waveform, the port latch or the pull-up
// assumes pin and override from the timer, direction bit from software
module tm0_port_pin (
  // from the timer
  input wire logic pin_out,
  input wire logic override,
  // port set by software
  input wire logic ddr,
  input wire logic port_val,
  // pad level
  output logic pad
);
  // no direction set: the driver is off and the pull-up wins
  assign pad = !ddr ? 1'b1 : override ? pin_out : port_val;
endmodule // tm0_port_pin
